/* File: rgf_top.sv */
// Operation
// [R01] receiver enabled only while rx_tx_select low and shutdown_n high
// [R02] three amplifier gain modes from register 0xB bits 6:5 or pins 7:6
// [R03] source bit 12 of register 0x8: one serial fields, zero gain pins
// [R04] amplifier code 11 max, 10 max-16dB, 0x max-33dB
// [R05] five-bit variable gain from register 0xB bits 4:0 or pins 5:1
// [R06] gain bits weigh 2,4,8,16,32 dB; all ones max, zeros min
// [R07] coarse lowpass from register 0x8 bits 1:0: 7.5, 8.5, 15, 18 MHz
// [R08] fine lowpass from register 0x7 bits 2:0: 90 to 110 percent
// [R09] highpass select high forces 600kHz AC coupling, field ignored
// [R10] highpass select low: register 0x7 bits 13:12 pick 100Hz, 4kHz, 30kHz
// [R11] controller pulses highpass select high, then low after offsets settle
// [R12] transmit calibration mode routes detector results onto baseband outputs
// [R13] registers written over chip select, serial clock and serial data
// [R14] fields hold until rewritten; decoders follow the selected source
`timescale 1ns/10ps
module rgf_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_tx_select,
  input wire logic shutdown_n,
  input wire logic highpass_select,
  input wire logic tx_cal_mode,
  input wire logic gain_pin_7,
  input wire logic gain_pin_6,
  input wire logic gain_pin_5,
  input wire logic gain_pin_4,
  input wire logic gain_pin_3,
  input wire logic gain_pin_2,
  input wire logic gain_pin_1,
  input wire logic ser_cs_n,
  input wire logic ser_clk,
  input wire logic ser_din,
  output rgf_pkg::rgf_ctrl_t ctrl_out,
  output logic rx_baseband_inphase_out,
  output logic rx_baseband_quadrature_out
);

  // ==========================================================================
  // pin synchronisers
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] pins_s;

  assign pins_raw = {rx_tx_select, shutdown_n, highpass_select, tx_cal_mode,
                     gain_pin_7, gain_pin_6, gain_pin_5, gain_pin_4,
                     gain_pin_3, gain_pin_2, gain_pin_1,
                     ser_cs_n, ser_clk, ser_din};

  rgf_sync #(
    .W(NSYNC)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(pins_raw),
    .q(pins_s)
  );

  logic rx_tx_select_s;
  logic shutdown_n_n_s;
  logic hp_sel_s;
  logic cal_s;
  rgf_pkg::rgf_gain_t pin_gain;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;

  assign rx_tx_select_s = pins_s[13];
  assign shutdown_n_n_s = pins_s[12];
  assign hp_sel_s = pins_s[11];
  assign cal_s = pins_s[10];
  assign pin_gain = pins_s[9:3];
  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[0];

  // ==========================================================================
  // serial shift port
  logic [rgf_pkg::FRAME_W-1:0] shift_r;
  logic [rgf_pkg::FRAME_W-1:0] shift_nxt;
  logic [4:0] bitcnt_r;
  logic [4:0] bitcnt_nxt;
  logic sclk_d_r;
  logic sclk_d_nxt;
  logic cs_n_d_r;
  logic cs_n_d_nxt;
  logic frame_done;

  always_comb
  begin
    shift_nxt = shift_r;
    bitcnt_nxt = bitcnt_r;
    sclk_d_nxt = sclk_s;
    cs_n_d_nxt = cs_n_s;
    frame_done = 1'b0;
    if (cs_n_s)
    begin
      bitcnt_nxt = '0;
      // rising chip select latches a complete frame
      frame_done = !cs_n_d_r && (bitcnt_r == rgf_pkg::FRAME_LEN); // [R13]
    end
    else if (sclk_s && !sclk_d_r)
    begin
      shift_nxt = {shift_r[rgf_pkg::FRAME_W-2:0], din_s}; // [R13]
      if (bitcnt_r != rgf_pkg::FRAME_LEN)
      begin
        bitcnt_nxt = bitcnt_r + rgf_pkg::BITCNT_ONE;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      shift_r <= '0;
      bitcnt_r <= '0;
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end
    else
    begin
      shift_r <= shift_nxt;
      bitcnt_r <= bitcnt_nxt;
      sclk_d_r <= sclk_d_nxt;
      cs_n_d_r <= cs_n_d_nxt;
    end
  end

  // ==========================================================================
  // write-only register file
  logic [rgf_pkg::DATA_W-1:0] filt_fine_r;
  logic [rgf_pkg::DATA_W-1:0] filt_fine_nxt;
  logic [rgf_pkg::DATA_W-1:0] filt_coarse_r;
  logic [rgf_pkg::DATA_W-1:0] filt_coarse_nxt;
  logic [rgf_pkg::DATA_W-1:0] rx_gain_r;
  logic [rgf_pkg::DATA_W-1:0] rx_gain_nxt;
  logic [rgf_pkg::ADDR_W-1:0] wr_addr;
  logic [rgf_pkg::DATA_W-1:0] wr_data;

  assign wr_data = shift_r[rgf_pkg::FRAME_W-1:rgf_pkg::ADDR_W];
  assign wr_addr = shift_r[rgf_pkg::ADDR_W-1:0];

  always_comb
  begin
    // fields hold until rewritten
    filt_fine_nxt = filt_fine_r; // [R14]
    filt_coarse_nxt = filt_coarse_r;
    rx_gain_nxt = rx_gain_r;
    if (frame_done)
    begin
      unique case (wr_addr)
        rgf_pkg::ADDR_FILTER_FINE: filt_fine_nxt = wr_data;
        rgf_pkg::ADDR_FILTER_COARSE: filt_coarse_nxt = wr_data;
        rgf_pkg::ADDR_RX_GAIN: rx_gain_nxt = wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      filt_fine_r <= rgf_pkg::RST_FILTER_FINE;
      filt_coarse_r <= rgf_pkg::RST_FILTER_COARSE;
      rx_gain_r <= rgf_pkg::RST_RX_GAIN;
    end
    else
    begin
      filt_fine_r <= filt_fine_nxt;
      filt_coarse_r <= filt_coarse_nxt;
      rx_gain_r <= rx_gain_nxt;
    end
  end

  // ==========================================================================
  // decoders
  rgf_pkg::rgf_gain_t reg_gain;
  rgf_pkg::rgf_gain_t sel_gain;
  rgf_pkg::rgf_ctrl_t ctrl_nxt;
  rgf_pkg::rgf_ctrl_t ctrl_r;
  logic serial_gain_source_bit;
  logic [1:0] hpf_field;
  logic bbi_nxt;
  logic bbq_nxt;
  logic bbi_r;
  logic bbq_r;

  assign serial_gain_source_bit = filt_coarse_r[rgf_pkg::SRC_BIT];
  assign reg_gain.lna_code = rx_gain_r[rgf_pkg::LNA_LSB +: 2]; // [R02]
  assign reg_gain.vga_code = rx_gain_r[rgf_pkg::VGA_LSB +: 5]; // [R05]
  assign sel_gain = serial_gain_source_bit ? reg_gain : pin_gain; // [R03]
  assign hpf_field = filt_fine_r[rgf_pkg::HPF_LSB +: 2];

  always_comb
  begin
    ctrl_nxt.rx_enable = !rx_tx_select_s && shutdown_n_n_s; // [R01]
    ctrl_nxt.cal_route = cal_s;
    if (!sel_gain.lna_code[1])
    begin
      ctrl_nxt.lna_mode = rgf_pkg::RGF_LNA_M33; // [R04]
    end
    else if (sel_gain.lna_code[0])
    begin
      ctrl_nxt.lna_mode = rgf_pkg::RGF_LNA_MAX; // [R04]
    end
    else
    begin
      ctrl_nxt.lna_mode = rgf_pkg::RGF_LNA_M16; // [R04]
    end
    // attenuation below max: weights 2..32 dB, inverted code times two
    ctrl_nxt.vga_atten_db = {~sel_gain.vga_code, 1'b0}; // [R06]
    ctrl_nxt.lpf_coarse = filt_coarse_r[rgf_pkg::COARSE_LSB +: 2]; // [R07]
    ctrl_nxt.lpf_fine = filt_fine_r[rgf_pkg::FINE_LSB +: 3]; // [R08]
    if (hp_sel_s)
    begin
      ctrl_nxt.hp_corner = rgf_pkg::RGF_HP_600KHZ; // [R09]
    end
    else if (hpf_field[0])
    begin
      ctrl_nxt.hp_corner = rgf_pkg::RGF_HP_4KHZ; // [R10]
    end
    else if (hpf_field[1])
    begin
      ctrl_nxt.hp_corner = rgf_pkg::RGF_HP_30KHZ; // [R10]
    end
    else
    begin
      ctrl_nxt.hp_corner = rgf_pkg::RGF_HP_100HZ; // [R10]
    end
    // baseband outputs: active path select, detector in calibration
    bbi_nxt = cal_s || ctrl_nxt.rx_enable; // [R12]
    bbq_nxt = cal_s || ctrl_nxt.rx_enable; // [R12]
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ctrl_r <= '0;
      bbi_r <= 1'b0;
      bbq_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt; // [R14]
      bbi_r <= bbi_nxt;
      bbq_r <= bbq_nxt;
    end
  end

  assign ctrl_out = ctrl_r;
  assign rx_baseband_inphase_out = bbi_r;
  assign rx_baseband_quadrature_out = bbq_r;

endmodule

/* File: rgf_pkg.sv */
package rgf_pkg;

  // ==========================================================================
  // serial frame: 14 data bits then 4 address bits, msb first
  localparam int DATA_W = 14;
  localparam int ADDR_W = 4;
  localparam int FRAME_W = DATA_W + ADDR_W;
  localparam logic [4:0] FRAME_LEN = 5'h12;
  localparam logic [4:0] BITCNT_ONE = 5'h01;

  // ==========================================================================
  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_FILTER_FINE = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_FILTER_COARSE = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_RX_GAIN = 4'hB;

  // ==========================================================================
  // reset values
  localparam logic [DATA_W-1:0] RST_FILTER_FINE = 14'h0002;
  localparam logic [DATA_W-1:0] RST_FILTER_COARSE = 14'h0001;
  localparam logic [DATA_W-1:0] RST_RX_GAIN = 14'h007F;

  // ==========================================================================
  // field positions
  localparam int FINE_LSB = 0;
  localparam int HPF_LSB = 12;
  localparam int COARSE_LSB = 0;
  localparam int SRC_BIT = 12;
  localparam int VGA_LSB = 0;
  localparam int LNA_LSB = 5;

  // ==========================================================================
  // decoded settings
  typedef enum logic [1:0] {
    RGF_LNA_MAX = 2'h0,
    RGF_LNA_M16 = 2'h1,
    RGF_LNA_M33 = 2'h3
  } rgf_lna_t;

  typedef enum logic [1:0] {
    RGF_HP_100HZ = 2'h0,
    RGF_HP_4KHZ = 2'h1,
    RGF_HP_30KHZ = 2'h3,
    RGF_HP_600KHZ = 2'h2
  } rgf_hp_t;

  typedef struct packed {
    logic [1:0] lna_code;
    logic [4:0] vga_code;
  } rgf_gain_t;

  typedef struct packed {
    logic rx_enable;
    logic cal_route;
    rgf_lna_t lna_mode;
    logic [5:0] vga_atten_db;
    logic [1:0] lpf_coarse;
    logic [2:0] lpf_fine;
    rgf_hp_t hp_corner;
  } rgf_ctrl_t;

endpackage

/* File: rgf_sync.sv */
`timescale 1ns/10ps
module rgf_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb
  begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end

endmodule

/* File: rgf_top_checker.sv */
`timescale 1ns/10ps
module rgf_top_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_tx_select,
  input wire logic shutdown_n,
  input wire logic highpass_select,
  input wire logic tx_cal_mode,
  input wire logic ser_cs_n,
  input wire rgf_pkg::rgf_ctrl_t ctrl_out,
  input wire logic rx_baseband_inphase_out,
  input wire logic rx_baseband_quadrature_out
);
  logic [2:0] up_r;
  logic [2:0] cs_hi_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // edges since reset, so $past sees only live pins
  always_ff @(posedge clk)
  begin
    if (!resetn)
      up_r <= 3'h0;
    else if (!up_r[2])
      up_r <= up_r + 3'h1;
  end
  // samples in a row with chip select high, saturating
  always_ff @(posedge clk)
  begin
    if (!resetn || !ser_cs_n)
      cs_hi_r <= 3'h0;
    else if (cs_hi_r != 3'h7)
      cs_hi_r <= cs_hi_r + 3'h1;
  end
  // ==========================================================================
  // properties
  property p_rx_en;
    up_r[2] |-> ctrl_out.rx_enable == $past(!rx_tx_select && shutdown_n, 3);
  endproperty
  a_rx_en: assert property (p_rx_en) else $error("rx enable wrong");
  property p_cal;
    up_r[2] |-> ctrl_out.cal_route == $past(tx_cal_mode, 3);
  endproperty
  a_cal: assert property (p_cal) else $error("cal route wrong");
  property p_bb;
    up_r[2] |-> rx_baseband_inphase_out ==
      $past((!rx_tx_select && shutdown_n) || tx_cal_mode, 3);
  endproperty
  a_bb: assert property (p_bb) else $error("baseband out wrong");
  property p_bb_pair;
    rx_baseband_quadrature_out == rx_baseband_inphase_out;
  endproperty
  a_bb_pair: assert property (p_bb_pair) else $error("i and q differ");
  property p_lna;
    ctrl_out.lna_mode != 2'h2;
  endproperty
  a_lna: assert property (p_lna) else $error("bad amplifier mode");
  property p_vga;
    ctrl_out.vga_atten_db[0] == 1'b0;
  endproperty
  a_vga: assert property (p_vga) else $error("gain step not 2dB");
  property p_hp_ac;
    up_r[2] && $past(highpass_select, 3) |-> ctrl_out.hp_corner == rgf_pkg::RGF_HP_600KHZ;
  endproperty
  a_hp_ac: assert property (p_hp_ac) else $error("ac coupling missing");
  property p_hp_dc;
    up_r[2] && !$past(highpass_select, 3) |-> ctrl_out.hp_corner != rgf_pkg::RGF_HP_600KHZ;
  endproperty
  a_hp_dc: assert property (p_hp_dc) else $error("near dc missing");
  // a write shows in the filter fields four samples after chip select rises
  property p_hold;
    up_r[2] && cs_hi_r == 3'h7 |-> $stable(ctrl_out.lpf_coarse) && $stable(ctrl_out.lpf_fine);
  endproperty
  a_hold: assert property (p_hold) else $error("filter field moved without a write");
endmodule
bind rgf_top rgf_top_checker rgf_top_checker_inst (.clk, .resetn, .rx_tx_select, .shutdown_n,
  .highpass_select, .tx_cal_mode, .ser_cs_n, .ctrl_out, .rx_baseband_inphase_out,
  .rx_baseband_quadrature_out);

/* File: rgf_ctl_model.sv */
`timescale 1ns/10ps
module rgf_ctl_model (
  input wire logic clk,
  output logic ser_cs_n,
  output logic ser_clk,
  output logic ser_din
);
  initial
  begin
    ser_cs_n = 1'b1;
    ser_clk = 1'b0;
    ser_din = 1'b0;
  end
  // data then address, msb first, din held around each rising clock
  task automatic send(input logic [3:0] a, input logic [13:0] d, input int n);
    logic [17:0] f;
    f = {d, a};
    @(negedge clk);
    ser_cs_n = 1'b0;
    for (int i = 17; i >= 18 - n; i--)
    begin
      ser_din = f[i];
      repeat (4) @(negedge clk);
      ser_clk = 1'b1;
      repeat (4) @(negedge clk);
      ser_clk = 1'b0;
    end
    repeat (4) @(negedge clk);
    ser_cs_n = 1'b1;
    ser_din = !ser_din;
    repeat (8) @(negedge clk);
  endtask
endmodule

/* File: rgf_top_tb.sv */
`timescale 1ns/10ps
module rgf_top_tb;
  logic clk, resetn, rt, sd, hp, cal, cs_n, sck, sdi, bbi, bbq;
  logic [6:0] gp;
  logic [13:0] r7, r8, rb;
  rgf_pkg::rgf_ctrl_t ctrl;
  int err_total, n_checks, cyc;
  rgf_top rgf_top_inst (.clk, .resetn, .rx_tx_select(rt), .shutdown_n(sd), .highpass_select(hp),
    .tx_cal_mode(cal), .gain_pin_7(gp[6]), .gain_pin_6(gp[5]), .gain_pin_5(gp[4]),
    .gain_pin_4(gp[3]), .gain_pin_3(gp[2]), .gain_pin_2(gp[1]), .gain_pin_1(gp[0]),
    .ser_cs_n(cs_n), .ser_clk(sck), .ser_din(sdi), .ctrl_out(ctrl),
    .rx_baseband_inphase_out(bbi), .rx_baseband_quadrature_out(bbq));
  rgf_ctl_model ctl_inst (.clk, .ser_cs_n(cs_n), .ser_clk(sck), .ser_din(sdi));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      err_total++;
      complete_run();
    end
  end
  // ==========================================================================
  // tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask
  function automatic logic [16:0] expc();
    logic [6:0] g;
    g = r8[12] ? rb[6:0] : gp;
    return {!rt && sd, cal, g[6] ? {1'b0, !g[5]} : 2'h3, 6'h3E - {g[4:0], 1'b0}, r8[1:0], r7[2:0],
      hp ? 2'h2 : r7[12] ? 2'h1 : {r7[13], r7[13]}};
  endfunction
  task automatic ck();
    repeat (8) @(negedge clk);
    chk("ctrl_out", expc(), ctrl);
    chk_bit("bb_inphase", (!rt && sd) || cal, bbi);
    chk_bit("bb_quadrature", (!rt && sd) || cal, bbq);
  endtask
  task automatic wr(input logic [3:0] a, input logic [13:0] d, input int n);
    ctl_inst.send(a, d, n);
    if (n == 18 && a == 4'h7) r7 = d;
    if (n == 18 && a == 4'h8) r8 = d;
    if (n == 18 && a == 4'hB) rb = d;
    ck();
  endtask
  // ==========================================================================
  // sequence
  initial
  begin
    {resetn, rt, sd, hp, cal, gp} = 12'h000;
    r7 = rgf_pkg::RST_FILTER_FINE;
    r8 = rgf_pkg::RST_FILTER_COARSE;
    rb = rgf_pkg::RST_RX_GAIN;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    ck();
    for (int i = 0; i < 16; i++)
    begin
      {rt, sd, cal, hp} = 4'(i);
      gp = 7'(i * 37);
      ck();
    end
    {rt, sd, cal} = 3'h2;
    hp = 1'b0;
    gp = 7'h55;
    for (int i = 0; i < 5; i++)
    begin
      wr(4'h8, 14'h1000 | 14'(i), 18);
      wr(4'hB, 14'(i * 53), 18);
      wr(4'h7, 14'((i << 12) + i), 18);
    end
    wr(4'h7, 14'h2001, 17);
    wr(4'h3, 14'h3FFF, 18);
    wr(4'h8, 14'h0002, 18);
    wr(4'h7, 14'h1003, 18);
    hp = 1'b1;
    ck();
    hp = 1'b0;
    ck();
    complete_run();
  end
endmodule
